// ===== logic/pwr_pkg.sv
// Purpose: Shared constants for the phase waveform reconstruction block
// Assumes: Samples are two's complement, one set of six per sample period
// Notes: Derivation codes select how phase waveforms are rebuilt
package pwr_pkg;
    // Default sample width and buffer depth
    localparam int SAMPLE_W = 24;
    localparam int FIFO_DEPTH = 4;
    // Voltage derivation codes
    localparam logic [2:0] VSEL_PASS = 3'h0;
    localparam logic [2:0] VSEL_DELTA = 3'h1;
    localparam logic [2:0] VSEL_WYE_NB = 3'h2;
    localparam logic [2:0] VSEL_DELTA_NB = 3'h3;
    localparam logic [2:0] VSEL_DELTA_SER = 3'h4;
    // Current derivation bit values
    localparam logic ISEL_MEASURED = 1'h0;
    localparam logic ISEL_DERIVED = 1'h1;
    // Sequence checker sample counters
    localparam int SEQ_CNT_W = 16;
    localparam logic [15:0] SEQ_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] SEQ_CNT_RST = 16'h0000;
    // Last phase seen crossing upward, Gray ordered
    typedef enum logic [1:0] {
        PWR_PH_NONE = 2'h0,
        PWR_PH_A = 2'h1,
        PWR_PH_B = 2'h3,
        PWR_PH_C = 2'h2
    } pwr_phase_e;
endpackage : pwr_pkg

// ===== logic/pwr_wave_if.sv
// Purpose: Stream carrier for reconstructed six-sample words
// Assumes: Word order is va, vb, vc, ia, ib, ic from the top bits down
// Notes: The monitor modport only watches, it never stalls
`timescale 1ns/100ps
interface pwr_wave_if #(parameter int W = 24);
    logic valid;      // Word on offer
    logic ready;      // Sink can take it
    logic [6*W-1:0] data;  // Packed phase samples
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
    modport mon (input valid, input data, input ready);
endinterface : pwr_wave_if

// ===== logic/pwr_fifo.sv
// Purpose: Small flop-based FIFO between derivation stage and consumer
// Assumes: Single clock, pop side may stall at will
// Notes: Full drops ready on the push side, so stalls reach the source
`timescale 1ns/100ps
module pwr_fifo import pwr_pkg::*; #(
    parameter int WIDTH = 144,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Push side
    pwr_wave_if.snk push,
    // Pop side
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words
    logic [AW-1:0] wr_q;  // Write pointer
    logic [AW-1:0] rd_q;  // Read pointer
    logic [AW:0] count_q;  // Words held
    logic do_push;
    logic do_pop;

    // Honest flags from the occupancy count
    assign push.ready = (count_q != DEPTH_C);
    assign o_valid = (count_q != '0);
    assign o_data = mem_q[rd_q];
    assign do_push = push.valid && push.ready;
    assign do_pop = o_valid && i_ready;

    // Storage has no reset, only valid words are ever read
    always_ff @(posedge i_clock) begin
        if (do_push) begin
            mem_q[wr_q] <= push.data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= (wr_q == LAST_C) ? '0 : wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= (rd_q == LAST_C) ? '0 : rd_q + 1'b1;
            end
        end
    end

    // Occupancy, push and pop together leave it unchanged
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q <= '0;
        end else if (do_push && !do_pop) begin
            count_q <= count_q + 1'b1;
        end else if (do_pop && !do_push) begin
            count_q <= count_q - 1'b1;
        end
    end
endmodule : pwr_fifo

// ===== logic/pwr_seq_check.sv
// Purpose: Phase sequence checker on reconstructed voltage waveforms
// Assumes: Upward zero crossings mark each phase, samples on stream fire
// Notes: Delta and series delta codes compare A and C gaps only, B is derived there
`timescale 1ns/100ps
module pwr_seq_check import pwr_pkg::*; #(
    parameter int W = SAMPLE_W
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Watched stream and mode
    pwr_wave_if.mon wave,
    input wire logic [2:0] i_voltage_derivation_select,
    // Status
    output logic o_seq_error
);
    logic fire;
    logic delta_mode;
    logic [2:0] neg;       // Sign of A, B, C this word
    logic [2:0] prev_neg_q;  // Sign of A, B, C last word
    logic [2:0] zc;        // Upward crossing per phase
    pwr_phase_e last_q;    // Last phase that crossed
    logic [SEQ_CNT_W-1:0] since_a_q;  // Words since A crossed
    logic [SEQ_CNT_W-1:0] since_c_q;  // Words since C crossed
    logic [SEQ_CNT_W-1:0] gap_ac_q;   // A to C gap, last measured
    logic bad;
    logic check;

    assign fire = wave.valid && wave.ready;
    assign delta_mode = (i_voltage_derivation_select == VSEL_DELTA) ||
        (i_voltage_derivation_select == VSEL_DELTA_SER);

    // One sign tracker per voltage phase
    for (genvar k = 0; k < 3; k++) begin : g_sign
        assign neg[k] = wave.data[6*W-1-k*W];
        assign zc[k] = fire && prev_neg_q[k] && !neg[k];
        always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
                prev_neg_q[k] <= 1'b0;
            end else if (fire) begin
                prev_neg_q[k] <= neg[k];
            end
        end
    end

    // Saturating sample counters since each A and C crossing
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            since_a_q <= SEQ_CNT_RST;
            since_c_q <= SEQ_CNT_RST;
            gap_ac_q <= SEQ_CNT_RST;
        end else if (fire) begin
            since_a_q <= zc[0] ? SEQ_CNT_RST :
                (since_a_q == SEQ_CNT_MAX) ? since_a_q : since_a_q + 1'b1;
            since_c_q <= zc[2] ? SEQ_CNT_RST :
                (since_c_q == SEQ_CNT_MAX) ? since_c_q : since_c_q + 1'b1;
            if (zc[2]) begin
                gap_ac_q <= since_a_q;
            end
        end
    end

    // Decide whether a crossing breaks the expected order
    always_comb begin
        bad = 1'b0;
        check = 1'b0;
        if (delta_mode) begin
            // C must lead A: short C to A gap
            if (zc[0] && last_q != PWR_PH_NONE) begin
                check = 1'b1;
                bad = (since_c_q >= gap_ac_q);
            end
        end else if (last_q != PWR_PH_NONE) begin
            // A follows C, B follows A, C follows B
            check = |zc;
            if (zc[0]) begin
                bad = (last_q != PWR_PH_C);
            end else if (zc[1]) begin
                bad = (last_q != PWR_PH_A);
            end else if (zc[2]) begin
                bad = (last_q != PWR_PH_B);
            end
        end
    end

    // Remember the most recent crossing, A first on a tie
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            last_q <= PWR_PH_NONE;
        end else if (zc[0]) begin
            last_q <= PWR_PH_A;
        end else if (zc[1] && !delta_mode) begin
            last_q <= PWR_PH_B;
        end else if (zc[2]) begin
            last_q <= PWR_PH_C;
        end
    end

    // Error holds until a crossing in the right order is seen
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_seq_error <= 1'b0;
        end else if (check) begin
            o_seq_error <= bad;
        end
    end

    property p_delta_lead;
        @(posedge i_clock) disable iff (!i_rst_n)
        (delta_mode && zc[0] && last_q != PWR_PH_NONE &&
            since_c_q >= gap_ac_q) |=> o_seq_error;
    endproperty
    a_delta_lead: assert property (p_delta_lead)
        else $error("delta lag of C not flagged");

    property p_abc_order;
        @(posedge i_clock) disable iff (!i_rst_n)
        (!delta_mode && zc[1] && !zc[0] && last_q == PWR_PH_C) |=>
            o_seq_error;
    endproperty
    a_abc_order: assert property (p_abc_order)
        else $error("B after C not flagged");
endmodule : pwr_seq_check

// ===== logic/pwr_reconstruct.sv
// Purpose: Rebuild phase voltage and current waveforms per service type
// Assumes: Input samples synchronous to i_clock, one word per handshake
// Notes: Derived values saturate to the sample width; codes 5 to 7 pass
`timescale 1ns/100ps
module pwr_reconstruct import pwr_pkg::*; #(
    parameter int W = SAMPLE_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Configuration
    input wire logic [2:0] i_voltage_derivation_select,
    input wire logic i_current_derivation_select,
    // Measured samples in
    input wire logic i_sample_valid,
    output logic o_sample_ready,
    input wire logic [W-1:0] i_va,
    input wire logic [W-1:0] i_vb,
    input wire logic [W-1:0] i_vc,
    input wire logic [W-1:0] i_ia,
    input wire logic [W-1:0] i_ib,
    input wire logic [W-1:0] i_ic,
    // Reconstructed waveforms out
    output logic o_wave_valid,
    input wire logic i_wave_ready,
    output logic [W-1:0] o_phase_a_compensated_voltage_wave,
    output logic [W-1:0] o_phase_b_compensated_voltage_wave,
    output logic [W-1:0] o_phase_c_compensated_voltage_wave,
    output logic [W-1:0] o_phase_a_current_wave,
    output logic [W-1:0] o_phase_b_current_wave,
    output logic [W-1:0] o_phase_c_current_wave,
    // Status
    output logic o_seq_error
);
    localparam int XW = W + 2;  // Headroom for sums of two samples

    pwr_wave_if #(.W(W)) stage_if ();  // Stage to FIFO stream

    logic take;          // Input word accepted this cycle
    logic stage_ready;   // Stage can load a new word
    logic stage_valid_q; // Stage holds a word
    logic [W-1:0] va_d, vb_d, vc_d, ib_d;  // Derived values
    logic [W-1:0] va_q, vb_q, vc_q;        // Staged voltages
    logic [W-1:0] ia_q, ib_q, ic_q;        // Staged currents
    logic [6*W-1:0] pop_data;

    // Sign extend a sample to the wide working width
    function automatic logic [XW-1:0] sx(input logic [W-1:0] v);
        return {{2{v[W-1]}}, v};
    endfunction : sx

    // Clamp a wide result to the sample range; avoids wrap on
    // full-scale inputs, at the cost of clipping their difference
    function automatic logic [W-1:0] sat(input logic [XW-1:0] x);
        logic [W-1:0] hi;
        logic [W-1:0] lo;
        hi = {1'b0, {(W-1){1'b1}}};
        lo = {1'b1, {(W-1){1'b0}}};
        if (!x[XW-1] && (x[XW-2:W-1] != '0)) begin
            return hi;
        end else if (x[XW-1] && (x[XW-2:W-1] != '1)) begin
            return lo;
        end
        return x[W-1:0];
    endfunction : sat

    // Stage stalls while it holds a word and the FIFO is full, and that stalls the source
    assign stage_ready = !stage_valid_q || stage_if.ready;
    assign o_sample_ready = stage_ready;
    assign take = i_sample_valid && stage_ready;

    // Voltage selection per derivation code
    always_comb begin
        va_d = i_va;
        vb_d = i_vb;
        vc_d = i_vc;
        case (i_voltage_derivation_select)
            VSEL_PASS: begin
                // Measured samples go straight on
                vb_d = i_vb;
            end
            VSEL_DELTA: begin
                // B becomes the A to C line voltage
                vb_d = sat(sx(i_va) - sx(i_vc));
            end
            VSEL_WYE_NB: begin
                // Two measured voltages, B rebuilt
                vb_d = sat(sx(i_va) - sx(i_vc));
            end
            VSEL_DELTA_NB: begin
                // B is the mirror of A
                vb_d = sat(-sx(i_va));
            end
            VSEL_DELTA_SER: begin
                // All three as line voltages from measured inputs
                va_d = sat(sx(i_va) - sx(i_vb));
                vb_d = sat(sx(i_va) - sx(i_vc));
                vc_d = sat(sx(i_vc) - sx(i_vb));
            end
            default: begin
                // Unused codes behave as pass-through
                vb_d = i_vb;
            end
        endcase
    end

    // Current B selection
    always_comb begin
        if (i_current_derivation_select == ISEL_DERIVED) begin
            ib_d = sat(-sx(i_ia) - sx(i_ic));
        end else begin
            ib_d = i_ib;
        end
    end

    // Stage occupancy
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage_valid_q <= 1'b0;
        end else if (take) begin
            stage_valid_q <= 1'b1;
        end else if (stage_if.ready) begin
            stage_valid_q <= 1'b0;
        end
    end

    // Stage data, loaded once per accepted sample period
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            va_q <= '0;
            vb_q <= '0;
            vc_q <= '0;
            ia_q <= '0;
            ib_q <= '0;
            ic_q <= '0;
        end else if (take) begin
            va_q <= va_d;
            vb_q <= vb_d;
            vc_q <= vc_d;
            ia_q <= i_ia;
            ib_q <= ib_d;
            ic_q <= i_ic;
        end
    end

    assign stage_if.valid = stage_valid_q;
    assign stage_if.data = {va_q, vb_q, vc_q, ia_q, ib_q, ic_q};

    // Four-word buffer toward the RMS and power logic
    pwr_fifo #(
        .WIDTH(6*W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .push(stage_if.snk),
        .o_valid(o_wave_valid),
        .i_ready(i_wave_ready),
        .o_data(pop_data)
    );

    assign o_phase_a_compensated_voltage_wave = pop_data[6*W-1 -: W];
    assign o_phase_b_compensated_voltage_wave = pop_data[5*W-1 -: W];
    assign o_phase_c_compensated_voltage_wave = pop_data[4*W-1 -: W];
    assign o_phase_a_current_wave = pop_data[3*W-1 -: W];
    assign o_phase_b_current_wave = pop_data[2*W-1 -: W];
    assign o_phase_c_current_wave = pop_data[W-1 -: W];

    // Order checker watches words as they enter the buffer
    pwr_seq_check #(
        .W(W)
    ) u_seq (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .wave(stage_if.mon),
        .i_voltage_derivation_select(i_voltage_derivation_select),
        .o_seq_error(o_seq_error)
    );

    // Accepted word under a given code
    sequence s_take_code(logic [2:0] code);
        take && i_voltage_derivation_select == code;
    endsequence

    property p_pass;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_take_code(VSEL_PASS) |=> va_q == $past(i_va) &&
            vb_q == $past(i_vb) && vc_q == $past(i_vc);
    endproperty
    a_pass: assert property (p_pass)
        else $error("pass-through altered a voltage");

    property p_delta_b;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_take_code(VSEL_DELTA) |=>
            vb_q == sat(sx($past(i_va)) - sx($past(i_vc)));
    endproperty
    a_delta_b: assert property (p_delta_b)
        else $error("delta B is not A minus C");

    // Derived B must reach the buffer intact, in the B slot
    property p_delta_reach;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_take_code(VSEL_DELTA) |=> stage_if.valid &&
            stage_if.data[5*W-1 -: W] ==
            sat(sx($past(i_va)) - sx($past(i_vc)));
    endproperty
    a_delta_reach: assert property (p_delta_reach)
        else $error("delta B lost before the buffer");

    property p_series;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_take_code(VSEL_DELTA_SER) |=>
            va_q == sat(sx($past(i_va)) - sx($past(i_vb))) &&
            vb_q == sat(sx($past(i_va)) - sx($past(i_vc))) &&
            vc_q == sat(sx($past(i_vc)) - sx($past(i_vb)));
    endproperty
    a_series: assert property (p_series)
        else $error("series delta voltages wrong");

    property p_wye_nb;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_take_code(VSEL_WYE_NB) |=> va_q == $past(i_va) &&
            vc_q == $past(i_vc) &&
            vb_q == sat(sx($past(i_va)) - sx($past(i_vc)));
    endproperty
    a_wye_nb: assert property (p_wye_nb)
        else $error("non-Blondel wye B wrong");

    property p_delta_nb;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_take_code(VSEL_DELTA_NB) |=> va_q == $past(i_va) &&
            vc_q == $past(i_vc) && vb_q == sat(-sx($past(i_va)));
    endproperty
    a_delta_nb: assert property (p_delta_nb)
        else $error("four-wire delta B not minus A");

    property p_ib_derived;
        @(posedge i_clock) disable iff (!i_rst_n)
        take && i_current_derivation_select |=>
            ib_q == sat(-sx($past(i_ia)) - sx($past(i_ic)));
    endproperty
    a_ib_derived: assert property (p_ib_derived)
        else $error("derived B current wrong");

    property p_ib_measured;
        @(posedge i_clock) disable iff (!i_rst_n)
        take && !i_current_derivation_select |=> ib_q == $past(i_ib);
    endproperty
    a_ib_measured: assert property (p_ib_measured)
        else $error("measured B current altered");

    property p_hold;
        @(posedge i_clock) disable iff (!i_rst_n)
        stage_valid_q && !stage_if.ready |=>
            stage_valid_q && $stable(stage_if.data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stalled stage word changed");

    // A and C voltages stay measured when only B is rebuilt
    property p_delta_ac;
        @(posedge i_clock) disable iff (!i_rst_n)
        s_take_code(VSEL_DELTA) |=> va_q == $past(i_va) &&
            vc_q == $past(i_vc);
    endproperty
    a_delta_ac: assert property (p_delta_ac)
        else $error("delta altered a measured A or C voltage");

    // A and C currents are never substituted, whatever the bit
    property p_currents;
        @(posedge i_clock) disable iff (!i_rst_n)
        take |=> ia_q == $past(i_ia) && ic_q == $past(i_ic);
    endproperty
    a_currents: assert property (p_currents)
        else $error("measured A or C current altered");

    // A staged word that the buffer accepts is offered downstream
    property p_push;
        @(posedge i_clock) disable iff (!i_rst_n)
        stage_if.valid && stage_if.ready |=> o_wave_valid;
    endproperty
    a_push: assert property (p_push)
        else $error("accepted word not offered downstream");

    // Head word stands until the consumer takes it
    property p_out_hold;
        @(posedge i_clock) disable iff (!i_rst_n)
        o_wave_valid && !i_wave_ready |=>
            o_wave_valid && $stable(pop_data);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("unread output word changed");
endmodule : pwr_reconstruct

// ===== tb/pwr_adc_model.sv
// Purpose: Sample source standing in for the converter and filter chain
// Assumes: Words offered at falling edge, held until taken
// Notes: Idle data toggles so stale words never look valid
`timescale 1ns/100ps
module pwr_adc_model #(
    parameter int W = 24
) (
    // Clock
    input wire logic i_clock,
    // Stream toward the block
    input wire logic i_ready,
    output logic o_valid,
    output logic [6*W-1:0] o_data
);
    logic [6*W-1:0] q[$];  // Words still to deliver
    int gap = 0;  // Idle cycles after each word, slow mode
    int idle = 0;  // Idle cycles left
    logic took = 1'h0;  // Word taken at last rising edge
    logic busy;  // Word still on offer
    // Handshake seen at the rising edge, before the block updates
    always @(posedge i_clock) took <= o_valid & i_ready;
    // Offer one word at a time, change only at falling edges
    initial begin
        o_valid = 1'h0;
        o_data = '0;
        forever begin
            @(negedge i_clock);
            busy = o_valid && !took;
            if (took) idle = gap;
            if (!busy && idle == 0 && q.size() > 0) begin
                o_data = q.pop_front();
                o_valid = 1'h1;
            end else if (!busy) begin
                // Released lines show the inverse, not the old word
                if (idle > 0) idle--;
                o_data = ~o_data;
                o_valid = 1'h0;
            end
        end
    end
endmodule : pwr_adc_model

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the waveform reconstruction block
// Assumes: Inputs change at falling edges, one clock domain
// Notes: Expected words come from a local model of each code
`timescale 1ns/100ps
module testbench import pwr_pkg::*;;
    localparam int W = SAMPLE_W;
    logic i_clock;
    logic i_rst_n;
    logic [2:0] vsel;  // Voltage derivation code
    logic isel;  // Current derivation bit
    logic rdy = 1'h0;  // Consumer ready
    logic stall = 1'h0;  // Hold consumer off
    logic sv, sr, wv, err;
    logic [W-1:0] a, b, c, x, y, z;
    logic [6*W-1:0] adc_d;
    logic [6*W-1:0] eq[$];  // Expected words in order
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    // Two boundary words that force saturation, then one in range
    logic [6*W-1:0] tv[3] = '{
        {24'h7FFFFF, 24'h000005, 24'h800000,
         24'h800000, 24'h000123, 24'h800000},
        {24'h800000, 24'h7FFFFF, 24'h000001,
         24'h7FFFFF, 24'hFFFFFE, 24'h000010},
        {24'h000064, 24'hFFFFCE, 24'h00001E,
         24'h000007, 24'h000009, 24'hFFFFFD}};

    pwr_adc_model #(.W(W)) u_adc (.i_clock(i_clock), .i_ready(sr),
        .o_valid(sv), .o_data(adc_d));

    pwr_reconstruct #(.W(W), .DEPTH(FIFO_DEPTH)) uut (
        .i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_voltage_derivation_select(vsel),
        .i_current_derivation_select(isel),
        .i_sample_valid(sv), .o_sample_ready(sr),
        .i_va(adc_d[143:120]), .i_vb(adc_d[119:96]),
        .i_vc(adc_d[95:72]), .i_ia(adc_d[71:48]),
        .i_ib(adc_d[47:24]), .i_ic(adc_d[23:0]),
        .o_wave_valid(wv), .i_wave_ready(rdy),
        .o_phase_a_compensated_voltage_wave(a),
        .o_phase_b_compensated_voltage_wave(b),
        .o_phase_c_compensated_voltage_wave(c),
        .o_phase_a_current_wave(x), .o_phase_b_current_wave(y),
        .o_phase_c_current_wave(z), .o_seq_error(err));

    // Clock, 10 ns period
    initial begin
        i_clock = 1'h0;
        forever #5 i_clock = ~i_clock;
    end

    // Clamp to the signed sample range
    function automatic logic [W-1:0] sat(input longint v);
        if (v > 64'sh7FFFFF) return 24'h7FFFFF;
        if (v < -64'sh800000) return 24'h800000;
        return v[W-1:0];
    endfunction : sat

    // Expected output word for one measured word
    function automatic logic [6*W-1:0] expw(input logic [2:0] cd,
            input logic ci, input logic [6*W-1:0] m);
        longint va, vb, vc;
        logic [W-1:0] ra, rb, rc, rib;
        va = $signed(m[143:120]);
        vb = $signed(m[119:96]);
        vc = $signed(m[95:72]);
        ra = m[143:120];
        rb = m[119:96];
        rc = m[95:72];
        case (cd)
            3'h1, 3'h2: rb = sat(va - vc);
            3'h3: rb = sat(-va);
            3'h4: begin
                ra = sat(va - vb);
                rb = sat(va - vc);
                rc = sat(vc - vb);
            end
            default: ;
        endcase
        // Derived or measured B current
        rib = ci ? sat(-longint'($signed(m[71:48]))
            - longint'($signed(m[23:0]))) : m[47:24];
        return {ra, rb, rc, m[71:48], rib, m[23:0]};
    endfunction : expw

    // Count a comparison, report a mismatch at once
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'h1) begin
            num_errors++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask : check

    // Queue a word for the source and its expectation
    task automatic send(input logic [6*W-1:0] m);
        eq.push_back(expw(vsel, isel, m));
        u_adc.q.push_back(m);
    endtask : send

    // Wait, bounded, until all words came out
    task automatic drain;
        int n;
        n = 0;
        while ((eq.size() > 0 || u_adc.q.size() > 0) && n < 2000) begin
            @(negedge i_clock);
            n++;
        end
        check(n < 2000, "drain timed out");
        repeat (4) @(negedge i_clock);
    endtask : drain

    // Square wave rising through zero at step off, period 12
    function automatic logic [W-1:0] sq(input int t, input int off);
        return ((t + 12 - off) % 12 < 6) ? 24'h100000 : 24'hF00000;
    endfunction : sq

    // Three periods of phase waves, then the sequence flag
    task automatic seq(input logic [2:0] cd, input int oa, input int ob,
            input int oc, input logic e);
        vsel = cd;
        for (int t = 0; t < 36; t++) begin
            send({sq(t, oa), ob < 0 ? 24'h000000 : sq(t, ob), sq(t, oc),
                72'h0});
        end
        drain;
        check(err === e, "sequence flag wrong");
    endtask : seq

    // Consumer: commits to a pop when it raises ready on a valid word
    always @(negedge i_clock) begin
        cyc++;
        rdy = !stall && (cyc % 3 != 0);
        if (rdy && wv === 1'h1) begin
            check(eq.size() > 0 && {a, b, c, x, y, z} === eq[0],
                "wave word mismatch");
            if (eq.size() > 0) eq.delete(0);
        end
    end

    // Closing report and verdict
    task print_verdict;
        $display("Checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // Watchdog at 20000 cycles, far beyond the expected run of under a thousand cycles
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        i_rst_n = 1'h0;
        vsel = 3'h0;
        isel = 1'h0;
        repeat (16) @(negedge i_clock);
        check(wv === 1'h0 && sr === 1'h1 && err === 1'h0, "reset state");
        i_rst_n = 1'h1;
        // Every code with both current settings, source gap stepping 0, 1, 2 per run
        for (int k = 0; k < 16; k++) begin
            vsel = k[3:1];
            isel = k[0];
            u_adc.gap = k % 3;
            foreach (tv[j]) send(tv[j]);
            drain;
        end
        // Fill stage and buffer until the input refuses, then empty
        u_adc.gap = 0;
        stall = 1'h1;
        repeat (6) send(tv[2]);
        repeat (20) @(negedge i_clock);
        check(sr === 1'h0 && wv === 1'h1, "buffer not full");
        stall = 1'h0;
        drain;
        check(sr === 1'h1 && wv === 1'h0, "buffer not empty");
        // Phase order checks, good then bad for each service except non-Blondel wye
        seq(VSEL_PASS, 0, 4, 8, 1'h0);
        seq(VSEL_PASS, 0, 8, 4, 1'h1);
        seq(VSEL_DELTA_NB, 0, 4, 8, 1'h0);
        seq(VSEL_DELTA_NB, 0, 4, 2, 1'h1);
        seq(VSEL_DELTA, 4, -1, 0, 1'h0);
        seq(VSEL_DELTA, 0, -1, 4, 1'h1);
        seq(VSEL_DELTA_SER, 4, -1, 0, 1'h0);
        seq(VSEL_DELTA_SER, 0, -1, 4, 1'h1);
        print_verdict();
    end
endmodule : testbench
